// [src/usbf_pkg.sv]
// Constants, register map and carrier types of the USB function endpoint FIFOs.
`default_nettype none
package usbf_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [15:0] ADDR_BULK_OUT_LENGTH = 16'h4214;
  localparam logic [15:0] ADDR_BULK_IN_FIFO    = 16'h4220;
  localparam logic [15:0] ADDR_EP0_IN_FIFO     = 16'h4300;
  localparam logic [15:0] ADDR_BULK_OUT_FIFO   = 16'h4304;
  localparam logic [15:0] ADDR_CTRL            = 16'h4308;
  localparam logic [15:0] ADDR_STATUS          = 16'h430c;

  // ==========================================================================
  // Control register fields
  localparam int unsigned CTRL_EP0_READY    = 0;
  localparam int unsigned CTRL_EP0_END      = 1;
  localparam int unsigned CTRL_BO_READY     = 2;
  localparam int unsigned CTRL_BI_READY     = 3;
  localparam int unsigned CTRL_BI_END       = 4;
  localparam int unsigned CTRL_BO_DMA       = 5;
  localparam int unsigned CTRL_BI_DMA       = 6;
  localparam logic [7:0]  CTRL_MASK         = 8'h7f;
  localparam logic [7:0]  CTRL_RESET        = 8'h00;

  // ==========================================================================
  // Status register fields
  localparam int unsigned ST_EP0_DATA       = 0;
  localparam int unsigned ST_BI_DATA        = 1;
  localparam int unsigned ST_BO_FLAG        = 2;
  localparam int unsigned ST_BI_FLAG        = 3;
  localparam int unsigned ST_STALL          = 4;

  // ==========================================================================
  // Sizes and fixed values
  localparam int unsigned BANK_BYTES        = 64;
  localparam logic [6:0]  BANK_FULL         = 7'h40;
  localparam logic [6:0]  CNT_ZERO          = 7'h00;
  localparam logic [6:0]  CNT_ONE           = 7'h01;
  localparam logic [5:0]  PTR_ONE           = 6'h01;
  localparam logic [7:0]  EMPTY_READ        = 8'h00;
  localparam logic [7:0]  LENGTH_RESET      = 8'h00;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } usbf_bus_s;

  typedef struct packed {
    logic in_token;
    logic in_ep;
    logic in_ack;
    logic in_abort;
    logic setup;
    logic status_stage;
  } usbf_sie_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       done;
    logic       ok;
  } usbf_rx_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       zlp;
    logic       nak;
  } usbf_tx_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } usbf_dma_s;

  typedef enum logic [2:0] {
    USBF_TX_IDLE = 3'b001,
    USBF_TX_SEND = 3'b010,
    USBF_TX_WAIT = 3'b100
  } usbf_tx_state_e;

endpackage
`default_nettype wire

// [src/usbf_bank2.sv]
// Two 64-byte banks of flip-flop storage with one write and one read port.
`default_nettype none
module usbf_bank2 (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       wr_i,
  input  wire logic       wbank_i,
  input  wire logic [5:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       rbank_i,
  input  wire logic [5:0] raddr_i,
  output logic      [7:0] rdata_o
);
  import usbf_pkg::*;

  typedef struct packed {
    logic [1:0][BANK_BYTES-1:0][7:0] mem;
  } usbf_bank_s;

  usbf_bank_s q;
  usbf_bank_s next_q;

  // ==========================================================================
  // Storage
  always_comb begin
    next_q = q;
    if (wr_i) begin
      next_q.mem[wbank_i][waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rdata_o = q.mem[rbank_i][raddr_i];

endmodule
`default_nettype wire

// [src/usbf_endpoint_fifos.sv]
// Endpoint0 IN FIFO and double-banked bulk OUT and bulk IN FIFOs of a USB function.
`default_nettype none
// How it works
// - Endpoint0 IN data goes out on an IN token only while ep0_in_ready is set.
// - A host ACK of Endpoint0 IN data clears ep0_in_ready.
// - Held Endpoint0 bytes with ep0_data_end set go out as a short packet.
// - Empty Endpoint0 FIFO with ep0_data_end set sends a zero-length packet.
// - A SETUP token empties the Endpoint0 IN FIFO and stops its transmission.
// - Status stage without data-stage ACK empties the Endpoint0 IN FIFO.
// - Reading the Endpoint0 IN FIFO returns 00H.
// - Bulk OUT uses two 64-byte banks swapping between bus and CPU; writes ignored.
// - Bulk OUT banks swap only if bus bank has data and CPU bank is empty.
// - Good bulk OUT packet swaps if allowed, sets flag, loads length, requests service.
// - In DMA mode bulk OUT bytes leave through the DMA read port.
// - CPU bank drained with a held packet swaps banks and clears bulk_out_ready.
// - Over-reading swaps if allowed, else returns the first byte again.
// - Data arriving while a packet waits behind a non-empty CPU bank stalls Endpoint2.
// - Reading an empty bulk OUT FIFO returns whatever the bank holds.
// - Length follows reception; a bad packet clears the received count without request.
// - Each bulk OUT read of a non-empty CPU bank decrements the length by one.
// - Length is the sum of both bulk OUT banks, read-only, reset to zero.
// - Bulk IN banks swap when the bus bank is empty and the CPU bank complete.
// - Bulk IN data goes out on an IN token only while bulk_in_ready is set.
// - Bulk IN addresses advance by themselves; reading the port returns 00H.
// - bulk_in_data_end closes the CPU bank as a short or zero-length packet.
// - After an acknowledged bulk IN packet: swap, set flag, interrupt or DMA.
// - While Endpoint2 is stalled the bulk OUT buffer is empty and not ready.
module usbf_endpoint_fifos (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  input  wire usbf_pkg::usbf_bus_s bus_i,
  output logic               [7:0] bus_rdata_o,
  input  wire usbf_pkg::usbf_sie_s sie_i,
  input  wire usbf_pkg::usbf_rx_s  rx_i,
  output usbf_pkg::usbf_tx_s       tx_o,
  output logic                     ep2_accept_o,
  output logic                     ep2_stall_o,
  input  wire usbf_pkg::usbf_dma_s dma_i,
  output logic               [7:0] ep2_dma_rdata_o,
  output logic                     ep1_irq_o,
  output logic                     ep2_irq_o,
  output logic                     ep1_dma_req_o,
  output logic                     ep2_dma_req_o
);
  import usbf_pkg::*;

  typedef struct packed {
    usbf_tx_state_e              tx_st;
    logic                        tx_ep;
    logic [6:0]                  tx_ptr;
    logic [6:0]                  tx_len;
    logic [BANK_BYTES-1:0][7:0]  e0_mem;
    logic [6:0]                  e0_cnt;
    logic [7:0]                  ctrl;
    logic                        bo_flag;
    logic                        bi_flag;
    logic                        stall;
    logic [1:0][6:0]             bo_cnt;
    logic [1:0]                  bo_valid;
    logic                        bo_cpu;
    logic [5:0]                  bo_rptr;
    logic [1:0][6:0]             bi_cnt;
    logic [1:0]                  bi_loaded;
    logic                        bi_cpu;
    logic [7:0]                  rdata;
    logic [7:0]                  dma_rdata;
    usbf_tx_s                    tx;
    logic                        ep1_irq;
    logic                        ep2_irq;
    logic                        ep1_dma_req;
    logic                        ep2_dma_req;
    logic                        accept;
  } usbf_state_s;

  usbf_state_s q;
  usbf_state_s next_q;

  function automatic logic usbf_hit(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction

  // ==========================================================================
  // Bank ports and access conditions
  logic       bo_sie;
  logic       bi_sie;
  logic       bo_dma;
  logic       bi_dma;
  logic       bo_take;
  logic       bo_overrun;
  logic       bo_cpu_rd;
  logic       bo_dma_rd;
  logic       bo_pop;
  logic [5:0] bo_raddr;
  logic [7:0] bo_rdata;
  logic       bi_push;
  logic [7:0] bi_wdata;
  logic [7:0] bi_rdata;
  logic       e0_busy;
  logic       e0_push;
  logic       rx_good;

  assign bo_sie     = ~q.bo_cpu;
  assign bi_sie     = ~q.bi_cpu;
  assign bo_dma     = q.ctrl[CTRL_BO_DMA];
  assign bi_dma     = q.ctrl[CTRL_BI_DMA];
  // Bytes land in the bus-side bank only while the endpoint is ready and not stalled.
  assign bo_take    = rx_i.valid & q.ctrl[CTRL_BO_READY] & ~q.stall &
                      ~q.bo_valid[bo_sie] & (q.bo_cnt[bo_sie] != BANK_FULL);
  assign bo_overrun = rx_i.valid & ~q.stall & q.bo_valid[bo_sie] &
                      (q.bo_cnt[q.bo_cpu] != CNT_ZERO);
  assign rx_good    = rx_i.done & rx_i.ok & ~q.stall;
  assign bo_cpu_rd  = bus_i.rd & usbf_hit(bus_i.addr, ADDR_BULK_OUT_FIFO) & ~bo_dma;
  assign bo_dma_rd  = dma_i.rd & bo_dma;
  assign bo_pop     = bo_cpu_rd | bo_dma_rd;
  // An empty CPU bank keeps pointing at its first byte.
  assign bo_raddr   = (q.bo_cnt[q.bo_cpu] == CNT_ZERO) ? 6'h00 : q.bo_rptr;
  assign bi_wdata   = bi_dma ? dma_i.wdata : bus_i.wdata;
  assign bi_push    = ((bus_i.wr & usbf_hit(bus_i.addr, ADDR_BULK_IN_FIFO) & ~bi_dma) |
                       (dma_i.wr & bi_dma)) &
                      ~q.bi_loaded[q.bi_cpu] & (q.bi_cnt[q.bi_cpu] != BANK_FULL);
  // Writes are refused while the bytes are on the wire, so a retry sends the same packet.
  assign e0_busy    = (q.tx_st != USBF_TX_IDLE) & ~q.tx_ep;
  assign e0_push    = bus_i.wr & usbf_hit(bus_i.addr, ADDR_EP0_IN_FIFO) &
                      (q.e0_cnt != BANK_FULL) & ~e0_busy;

  usbf_bank2 u_bulk_out (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .wr_i      (bo_take),
    .wbank_i   (bo_sie),
    .waddr_i   (q.bo_cnt[bo_sie][5:0]),
    .wdata_i   (rx_i.data),
    .rbank_i   (q.bo_cpu),
    .raddr_i   (bo_raddr),
    .rdata_o   (bo_rdata)
  );

  usbf_bank2 u_bulk_in (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .wr_i      (bi_push),
    .wbank_i   (q.bi_cpu),
    .waddr_i   (q.bi_cnt[q.bi_cpu][5:0]),
    .wdata_i   (bi_wdata),
    .rbank_i   (bi_sie),
    .raddr_i   (q.tx_ptr[5:0]),
    .rdata_o   (bi_rdata)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    next_q             = q;
    next_q.rdata       = EMPTY_READ;
    next_q.dma_rdata   = EMPTY_READ;
    next_q.tx          = '0;
    next_q.ep1_irq     = 1'b0;
    next_q.ep2_irq     = 1'b0;

    // Software writes; hardware events below may override them.
    if (bus_i.wr) begin
      if (usbf_hit(bus_i.addr, ADDR_CTRL)) begin
        next_q.ctrl = bus_i.wdata & CTRL_MASK;
      end else if (usbf_hit(bus_i.addr, ADDR_STATUS)) begin
        if (bus_i.wdata[ST_BO_FLAG]) begin
          next_q.bo_flag = 1'b0;
        end
        if (bus_i.wdata[ST_BI_FLAG]) begin
          next_q.bi_flag = 1'b0;
        end
        if (bus_i.wdata[ST_STALL]) begin
          next_q.stall = 1'b0;
        end
      end
    end

    // Register reads answer in the following cycle.
    if (bus_i.rd) begin
      if (usbf_hit(bus_i.addr, ADDR_BULK_OUT_LENGTH)) begin
        next_q.rdata = {1'b0, q.bo_cnt[0]} + {1'b0, q.bo_cnt[1]};
      end else if (usbf_hit(bus_i.addr, ADDR_BULK_OUT_FIFO)) begin
        next_q.rdata = bo_dma ? EMPTY_READ : bo_rdata;
      end else if (usbf_hit(bus_i.addr, ADDR_CTRL)) begin
        next_q.rdata = q.ctrl;
      end else if (usbf_hit(bus_i.addr, ADDR_STATUS)) begin
        next_q.rdata = {3'b000, q.stall, q.bi_flag, q.bo_flag,
                        (q.bi_cnt[q.bi_cpu] != CNT_ZERO) | (|q.bi_loaded),
                        (q.e0_cnt != CNT_ZERO)};
      end else begin
        next_q.rdata = EMPTY_READ;
      end
    end
    if (bo_dma_rd) begin
      next_q.dma_rdata = bo_rdata;
    end

    // Endpoint0 IN fill.
    if (e0_push) begin
      next_q.e0_mem[q.e0_cnt[5:0]] = bus_i.wdata;
      next_q.e0_cnt                = q.e0_cnt + CNT_ONE;
    end

    // Bulk IN fill; a full bank is complete by itself.
    if (bi_push) begin
      next_q.bi_cnt[q.bi_cpu] = q.bi_cnt[q.bi_cpu] + CNT_ONE;
      if (q.bi_cnt[q.bi_cpu] == BANK_FULL - CNT_ONE) begin
        next_q.bi_loaded[q.bi_cpu] = 1'b1;
      end
    end
    if (next_q.ctrl[CTRL_BI_END] && !next_q.bi_loaded[q.bi_cpu]) begin
      next_q.bi_loaded[q.bi_cpu] = 1'b1;
      next_q.ctrl[CTRL_BI_END]   = 1'b0;
    end

    // IN transactions towards the serial interface engine.
    case (q.tx_st)
      USBF_TX_IDLE: begin
        if (sie_i.in_token && !sie_i.in_ep) begin
          if (q.ctrl[CTRL_EP0_READY] &&
              (q.e0_cnt == BANK_FULL || q.ctrl[CTRL_EP0_END])) begin
            next_q.tx_ep  = 1'b0;
            next_q.tx_len = q.e0_cnt;
            next_q.tx_ptr = CNT_ZERO;
            if (q.e0_cnt == CNT_ZERO) begin
              next_q.tx.zlp = 1'b1;
              next_q.tx_st  = USBF_TX_WAIT;
            end else begin
              next_q.tx_st  = USBF_TX_SEND;
            end
          end else begin
            next_q.tx.nak = 1'b1;
          end
        end else if (sie_i.in_token) begin
          if (q.ctrl[CTRL_BI_READY] && q.bi_loaded[bi_sie]) begin
            next_q.tx_ep  = 1'b1;
            next_q.tx_len = q.bi_cnt[bi_sie];
            next_q.tx_ptr = CNT_ZERO;
            if (q.bi_cnt[bi_sie] == CNT_ZERO) begin
              next_q.tx.zlp = 1'b1;
              next_q.tx_st  = USBF_TX_WAIT;
            end else begin
              next_q.tx_st  = USBF_TX_SEND;
            end
          end else begin
            next_q.tx.nak = 1'b1;
          end
        end
      end
      USBF_TX_SEND: begin
        next_q.tx.valid = 1'b1;
        next_q.tx.data  = q.tx_ep ? bi_rdata : q.e0_mem[q.tx_ptr[5:0]];
        next_q.tx_ptr   = q.tx_ptr + CNT_ONE;
        if (q.tx_ptr + CNT_ONE == q.tx_len) begin
          next_q.tx.last = 1'b1;
          next_q.tx_st   = USBF_TX_WAIT;
        end
      end
      USBF_TX_WAIT: begin
        if (sie_i.in_ack) begin
          next_q.tx_st = USBF_TX_IDLE;
          if (!q.tx_ep) begin
            next_q.ctrl[CTRL_EP0_READY] = 1'b0;
            next_q.ctrl[CTRL_EP0_END]   = 1'b0;
            next_q.e0_cnt               = CNT_ZERO;
          end else begin
            next_q.bi_loaded[bi_sie] = 1'b0;
            next_q.bi_cnt[bi_sie]    = CNT_ZERO;
            next_q.bi_flag           = 1'b1;
            next_q.ep1_irq           = ~bi_dma;
          end
        end else if (sie_i.in_abort) begin
          next_q.tx_st = USBF_TX_IDLE;
        end
      end
      default: begin
        next_q.tx_st = USBF_TX_IDLE;
      end
    endcase

    // Endpoint0 flush on a new SETUP or an unacknowledged data stage.
    if (sie_i.setup ||
        (sie_i.status_stage && (q.e0_cnt != CNT_ZERO || q.ctrl[CTRL_EP0_END]))) begin
      next_q.e0_cnt             = CNT_ZERO;
      next_q.ctrl[CTRL_EP0_END] = 1'b0;
      if (!q.tx_ep) begin
        next_q.tx_st = USBF_TX_IDLE;
      end
    end

    // Bulk IN swap.
    if (!next_q.bi_loaded[bi_sie] && next_q.bi_loaded[q.bi_cpu]) begin
      next_q.bi_cpu = bi_sie;
    end

    // Bulk OUT reception.
    if (bo_take) begin
      next_q.bo_cnt[bo_sie] = q.bo_cnt[bo_sie] + CNT_ONE;
    end
    if (rx_good) begin
      next_q.bo_valid[bo_sie] = 1'b1;
      next_q.bo_flag          = 1'b1;
      next_q.ep2_irq          = ~bo_dma;
    end else if (rx_i.done && !q.stall) begin
      next_q.bo_cnt[bo_sie] = CNT_ZERO;
    end

    // Bulk OUT drain by CPU or DMA.
    if (bo_pop && q.bo_cnt[q.bo_cpu] != CNT_ZERO) begin
      next_q.bo_cnt[q.bo_cpu] = q.bo_cnt[q.bo_cpu] - CNT_ONE;
      next_q.bo_rptr          = q.bo_rptr + PTR_ONE;
    end

    // Bulk OUT swap; a swap not caused by a fresh packet withdraws readiness.
    if (next_q.bo_valid[bo_sie] && next_q.bo_cnt[q.bo_cpu] == CNT_ZERO) begin
      next_q.bo_cpu             = bo_sie;
      next_q.bo_valid           = 2'b00;
      next_q.bo_cnt[q.bo_cpu]   = CNT_ZERO;
      next_q.bo_rptr            = 6'h00;
      if (!rx_good) begin
        next_q.ctrl[CTRL_BO_READY] = 1'b0;
      end
    end

    // Overrun stalls the endpoint; a stalled endpoint holds nothing.
    if (bo_overrun) begin
      next_q.stall = 1'b1;
    end
    if (next_q.stall) begin
      next_q.bo_cnt              = '0;
      next_q.bo_valid            = 2'b00;
      next_q.bo_rptr             = 6'h00;
      next_q.ctrl[CTRL_BO_READY] = 1'b0;
    end

    // Service requests.
    next_q.ep2_dma_req = next_q.ctrl[CTRL_BO_DMA] &
                         (next_q.bo_cnt[next_q.bo_cpu] != CNT_ZERO);
    next_q.ep1_dma_req = next_q.ctrl[CTRL_BI_DMA] &
                         ~next_q.bi_loaded[next_q.bi_cpu];
    next_q.accept      = next_q.ctrl[CTRL_BO_READY] & ~next_q.stall;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q       <= '0;
      q.tx_st <= USBF_TX_IDLE;
      q.ctrl  <= CTRL_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign bus_rdata_o     = q.rdata;
  assign tx_o            = q.tx;
  assign ep2_accept_o    = q.accept;
  assign ep2_stall_o     = q.stall;
  assign ep2_dma_rdata_o = q.dma_rdata;
  assign ep1_irq_o       = q.ep1_irq;
  assign ep2_irq_o       = q.ep2_irq;
  assign ep1_dma_req_o   = q.ep1_dma_req;
  assign ep2_dma_req_o   = q.ep2_dma_req;

endmodule
`default_nettype wire

// [sim/usbf_fifo_sva.sv]
// Port-level assertions for the endpoint FIFO block.
`default_nettype none
module usbf_fifo_sva (
  input wire logic                clk_sys_i,
  input wire logic                rst_i,
  input wire usbf_pkg::usbf_bus_s bus_i,
  input wire logic          [7:0] bus_rdata_o,
  input wire usbf_pkg::usbf_sie_s sie_i,
  input wire usbf_pkg::usbf_rx_s  rx_i,
  input wire usbf_pkg::usbf_tx_s  tx_o,
  input wire logic                ep2_accept_o,
  input wire logic                ep2_stall_o,
  input wire usbf_pkg::usbf_dma_s dma_i,
  input wire logic          [7:0] ep2_dma_rdata_o,
  input wire logic                ep1_irq_o,
  input wire logic                ep2_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import usbf_pkg::*;
  // ====================
  // Clocking and sequences
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_answer;
    (tx_o.nak || tx_o.zlp) or (!tx_o.zlp ##1 tx_o.valid);
  endsequence
  sequence s_last_quiet;
    tx_o.valid ##1 !tx_o.valid;
  endsequence
  // ====================
  // Assertions
  a_ep0_rd_zero: assert property (
    bus_i.rd && bus_i.addr == ADDR_EP0_IN_FIFO |=> bus_rdata_o == EMPTY_READ)
    else $error("ep0 fifo read not zero");
  a_bi_rd_zero: assert property (
    bus_i.rd && bus_i.addr == ADDR_BULK_IN_FIFO |=> bus_rdata_o == EMPTY_READ)
    else $error("bulk in fifo read not zero");
  a_dma_rd_idle: assert property (!$past(dma_i.rd) |-> ep2_dma_rdata_o == 8'h00)
    else $error("dma read data without a read");
  a_stall_closes: assert property (ep2_stall_o |-> !ep2_accept_o)
    else $error("stalled endpoint still accepts");
  a_irq_good: assert property (ep2_irq_o |-> $past(rx_i.done && rx_i.ok))
    else $error("bulk out request without good packet");
  a_bad_quiet: assert property (rx_i.done && !rx_i.ok |=> !ep2_irq_o)
    else $error("bad packet raised a request");
  a_ep1_irq_ack: assert property (
    ep1_irq_o |-> $past(sie_i.in_ack) || $past(sie_i.in_ack, 2))
    else $error("bulk in request without ack");
  a_token_answer: assert property (sie_i.in_token |=> s_answer)
    else $error("token not answered next cycle");
  a_burst_run: assert property (tx_o.valid && !tx_o.last |=> tx_o.valid)
    else $error("gap inside a packet");
  a_last_stop: assert property (tx_o.last |-> s_last_quiet)
    else $error("packet did not end after last");
  a_zlp_alone: assert property (tx_o.zlp |-> !tx_o.valid && !tx_o.nak)
    else $error("zero-length packet mixed with data");
endmodule

bind usbf_endpoint_fifos usbf_fifo_sva u_sva (.clk_sys_i, .rst_i, .bus_i, .bus_rdata_o,
  .sie_i, .rx_i, .tx_o, .ep2_accept_o, .ep2_stall_o, .dma_i, .ep2_dma_rdata_o,
  .ep1_irq_o, .ep2_irq_o);
`default_nettype wire

// [sim/usbf_host_model.sv]
// Behavioural host and serial engine facing the endpoint FIFO token and packet side.
`default_nettype none
module usbf_host_model (
  input  wire usbf_pkg::usbf_tx_s  tx_i,
  input  wire logic                clk_sys_i,
  output var usbf_pkg::usbf_sie_s  sie_o,
  output var usbf_pkg::usbf_rx_s   rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import usbf_pkg::*;
  logic [7:0] got [0:63];

  initial begin
    sie_o = '0;
    rx_o  = '0;
  end

  // ====================
  // IN transfer: token, collect answer, then ack unless it was a NAK.
  task automatic in_xfer(input logic ep, output logic nak, output logic zlp, output int n);
    int k;
    nak = 1'b0;
    zlp = 1'b0;
    n = 0;
    @(posedge clk_sys_i);
    sie_o.in_token <= 1'b1;
    sie_o.in_ep    <= ep;
    @(posedge clk_sys_i);
    sie_o.in_token <= 1'b0;
    for (k = 0; k < 70; k++) begin
      @(posedge clk_sys_i);
      nak = tx_i.nak;
      zlp = tx_i.zlp;
      if (tx_i.valid === 1'b1 && n < 64) begin
        got[n] = tx_i.data;
        n++;
      end
      if (nak === 1'b1 || zlp === 1'b1 || tx_i.last === 1'b1) break;
    end
    // A NAK carries no data, so the host never acknowledges it.
    if (nak !== 1'b1) begin
      sie_o.in_ack <= 1'b1;
      @(posedge clk_sys_i);
      sie_o.in_ack <= 1'b0;
    end
  endtask

  // ====================
  // OUT packet: n bytes counting up from base, closed good or bad.
  task automatic out_pkt(input int n, input logic [7:0] base, input logic ok);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge clk_sys_i);
      rx_o.valid <= 1'b1;
      rx_o.data  <= base + 8'(i);
    end
    @(posedge clk_sys_i);
    rx_o.valid <= 1'b0;
    // Stale data is inverted so that a byte taken without valid shows up.
    rx_o.data  <= ~rx_o.data;
    rx_o.done  <= 1'b1;
    rx_o.ok    <= ok;
    @(posedge clk_sys_i);
    rx_o.done  <= 1'b0;
    rx_o.ok    <= 1'b0;
  endtask

  // Control events: a SETUP token or entry to the status stage.
  task automatic pulse(input logic setup);
    @(posedge clk_sys_i);
    sie_o.setup        <= setup;
    sie_o.status_stage <= ~setup;
    @(posedge clk_sys_i);
    sie_o.setup        <= 1'b0;
    sie_o.status_stage <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the USB function endpoint FIFOs.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import usbf_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       rst_i = 1'b1;
  usbf_bus_s  bus_i = '0;
  usbf_dma_s  dma_i = '0;
  usbf_sie_s  sie_i;
  usbf_rx_s   rx_i;
  usbf_tx_s   tx_o;
  logic [7:0] bus_rdata_o, ep2_dma_rdata_o, d;
  logic       ep2_accept_o, ep2_stall_o, ep1_irq_o, ep2_irq_o;
  logic       ep1_dma_req_o, ep2_dma_req_o, nk, zl;
  int         fails = 0, n_checks = 0, n_irq1 = 0, n_irq2 = 0, n, b;

  usbf_endpoint_fifos DUT (.clk_sys_i, .rst_i, .bus_i, .bus_rdata_o, .sie_i, .rx_i, .tx_o,
    .ep2_accept_o, .ep2_stall_o, .dma_i, .ep2_dma_rdata_o, .ep1_irq_o, .ep2_irq_o,
    .ep1_dma_req_o, .ep2_dma_req_o);
  usbf_host_model host (.tx_i(tx_o), .clk_sys_i, .sie_o(sie_i), .rx_o(rx_i));

  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    if (ep1_irq_o === 1'b1) n_irq1++;
    if (ep2_irq_o === 1'b1) n_irq2++;
  end

  // ====================
  // Bus and compare helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    bus_i.wr <= 1'b1; bus_i.addr <= a; bus_i.wdata <= v;
    @(posedge clk_sys_i);
    bus_i.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample exactly there.
  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input string m);
    @(posedge clk_sys_i);
    bus_i.rd <= 1'b1; bus_i.addr <= a;
    @(posedge clk_sys_i);
    bus_i.rd <= 1'b0;
    @(posedge clk_sys_i);
    d = bus_rdata_o;
    if (m != "") chk(d, e, m);
  endtask
  task automatic dma_chk(input logic [7:0] e);
    @(posedge clk_sys_i);
    dma_i.rd <= 1'b1;
    @(posedge clk_sys_i);
    dma_i.rd <= 1'b0;
    @(posedge clk_sys_i);
    chk(ep2_dma_rdata_o, e, "dma byte");
  endtask

  // ====================
  // Scenarios
  task automatic t_reset;
    rchk(ADDR_BULK_OUT_LENGTH, 8'h00, "length");
    rchk(ADDR_CTRL, 8'h00, "ctrl");
    rchk(ADDR_STATUS, 8'h00, "status");
    rchk(ADDR_EP0_IN_FIFO, 8'h00, "ep0 read");
    rchk(ADDR_BULK_IN_FIFO, 8'h00, "bulk in read");
    rchk(16'h4400, 8'h00, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_ep0;
    host.in_xfer(1'b0, nk, zl, n);
    chk(8'(nk), 8'h01, "ep0 nak");
    wr(ADDR_EP0_IN_FIFO, 8'h5a);
    wr(ADDR_EP0_IN_FIFO, 8'ha5);
    wr(ADDR_CTRL, 8'h03);
    rchk(ADDR_STATUS, 8'h01, "ep0 data");
    host.in_xfer(1'b0, nk, zl, n);
    chk(8'(n), 8'h02, "ep0 length");
    chk(host.got[0], 8'h5a, "ep0 b0");
    chk(host.got[1], 8'ha5, "ep0 b1");
    rchk(ADDR_CTRL, 8'h00, "");
    chk(d & 8'h01, 8'h00, "ep0 ready");
    wr(ADDR_CTRL, 8'h03);
    host.in_xfer(1'b0, nk, zl, n);
    chk(8'(zl), 8'h01, "ep0 zlp");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_EP0_IN_FIFO, 8'h11);
    host.pulse(1'b1);
    rchk(ADDR_STATUS, 8'h00, "setup flush");
    wr(ADDR_EP0_IN_FIFO, 8'h22);
    host.pulse(1'b0);
    rchk(ADDR_STATUS, 8'h00, "status flush");
    $display("test ep0 done");
  endtask
  task automatic t_out;
    wr(ADDR_CTRL, 8'h04);
    host.out_pkt(3, 8'h30, 1'b1);
    rchk(ADDR_BULK_OUT_LENGTH, 8'h03, "len");
    chk(8'(n_irq2), 8'h01, "irq");
    rchk(ADDR_STATUS, 8'h04, "out flag");
    wr(ADDR_BULK_OUT_FIFO, 8'hff);
    rchk(ADDR_BULK_OUT_FIFO, 8'h30, "b0");
    rchk(ADDR_BULK_OUT_LENGTH, 8'h02, "dec");
    rchk(ADDR_BULK_OUT_FIFO, 8'h31, "b1");
    rchk(ADDR_BULK_OUT_FIFO, 8'h32, "b2");
    rchk(ADDR_BULK_OUT_LENGTH, 8'h00, "drained");
    rchk(ADDR_BULK_OUT_FIFO, 8'h30, "over-read");
    wr(ADDR_STATUS, 8'h04);
    host.out_pkt(2, 8'h40, 1'b0);
    rchk(ADDR_BULK_OUT_LENGTH, 8'h00, "bad len");
    chk(8'(n_irq2), 8'h01, "bad irq");
    host.out_pkt(2, 8'h50, 1'b1);
    host.out_pkt(3, 8'h60, 1'b1);
    rchk(ADDR_BULK_OUT_LENGTH, 8'h05, "sum");
    rchk(ADDR_BULK_OUT_FIFO, 8'h50, "held");
    rchk(ADDR_BULK_OUT_FIFO, 8'h51, "held");
    rchk(ADDR_CTRL, 8'h00, "");
    chk(d & 8'h04, 8'h00, "ready clr");
    rchk(ADDR_BULK_OUT_LENGTH, 8'h03, "swapped");
    rchk(ADDR_BULK_OUT_FIFO, 8'h60, "next");
    $display("test bulk out done");
  endtask
  task automatic t_stall;
    wr(ADDR_CTRL, 8'h04);
    host.out_pkt(1, 8'h70, 1'b1);
    host.out_pkt(1, 8'h71, 1'b1);
    host.out_pkt(1, 8'h72, 1'b1);
    rchk(ADDR_BULK_OUT_LENGTH, 8'h00, "stall len");
    chk(8'(ep2_stall_o), 8'h01, "stall");
    chk(8'(ep2_accept_o), 8'h00, "accept");
    wr(ADDR_STATUS, 8'h1c);
    wr(ADDR_CTRL, 8'h24);
    b = n_irq2;
    host.out_pkt(2, 8'h80, 1'b1);
    rchk(ADDR_BULK_OUT_FIFO, 8'h00, "dma bus");
    chk(8'(ep2_dma_req_o), 8'h01, "dma req");
    dma_chk(8'h80);
    dma_chk(8'h81);
    chk(8'(n_irq2 - b), 8'h00, "dma no irq");
    $display("test stall and dma done");
  endtask
  task automatic t_in;
    wr(ADDR_CTRL, 8'h00);
    host.in_xfer(1'b1, nk, zl, n);
    chk(8'(nk), 8'h01, "in nak");
    wr(ADDR_BULK_IN_FIFO, 8'h91);
    wr(ADDR_BULK_IN_FIFO, 8'h92);
    wr(ADDR_BULK_IN_FIFO, 8'h93);
    wr(ADDR_CTRL, 8'h18);
    host.in_xfer(1'b1, nk, zl, n);
    chk(8'(n), 8'h03, "in length");
    chk(host.got[2], 8'h93, "in order");
    rchk(ADDR_STATUS, 8'h00, "");
    chk(d & 8'h08, 8'h08, "in flag");
    chk(8'(n_irq1), 8'h01, "in irq");
    wr(ADDR_CTRL, 8'h58);
    host.in_xfer(1'b1, nk, zl, n);
    chk(8'(zl), 8'h01, "in zlp");
    chk(8'(ep1_dma_req_o), 8'h01, "in dma req");
    $display("test bulk in done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset();
    t_ep0();
    t_out();
    t_stall();
    t_in();
    stop_test();
  end
  // A run takes about two hundred cycles; a hundred times that is a hang.
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
